// file: hdl/isr_slave_core.sv
// Overview of operation
// - write-address match: clear direction bit, buffer the address, pull SDA low
// - no acknowledge while buffer full or receive overflow is already set
// - irq flag set on ninth falling edge per byte; firmware clears it
// - stretch enable holds SCL low after each acked data byte still unread at the ninth fall, until release
// - read-address match: set direction, buffer address, ack, always hold SCL
// - firmware buffer write also loads the shift register; clock held until firmware sets release bit
// - transmit bits change on SCL falling edges, stable while SCL high
// - master ack latched on ninth rise; high ends transfer, clears full, update and direction flags, sets release bit
// - transmit always stretches after the read address byte, in 7-bit and 10-bit addressing
// - 7-bit receive, stretch on, buffer full at ninth fall: clear release bit
// - cleared release bit pulls SCL low until firmware sets it
// - buffer read before ninth fall: no release clear, no stretch
// - firmware may set the release bit at any time
// - 10-bit address stretch follows address update flag, freed by address write
// - address update flag set after high address byte and write low byte
// - buffer-full release clearing only on data bytes, never address bytes
// - 7-bit transmit: release bit cleared at ninth fall if buffer empty
// - buffer written before ninth fall: no release clear, no stretch
// - stretch disabled: receive never clears the release bit
// - bits sampled on SCL rise; address compared at eighth fall
// - 10-bit first byte is prefix, two high bits, write bit
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for independent bits
module isr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_r <= RST_VAL;
            Q <= RST_VAL;
        end else begin
            meta_r <= D;
            Q <= meta_r;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module isr_slave_core
    import isr_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic LINK_CLK,
    input wire logic STRETCH_ENABLE,
    input wire logic TEN_BIT_MODE,
    input wire logic BUF_WR,
    input wire logic [7:0] BUF_WDATA,
    input wire logic BUF_RD,
    input wire logic ADDR_WR,
    input wire logic [7:0] ADDR_WDATA,
    input wire logic CKP_SET,
    input wire logic IRQ_CLR,
    input wire logic OVF_CLR,
    output logic [7:0] BUF_RDATA,
    output logic BUFFER_FULL,
    output logic RX_OVERFLOW,
    output logic IRQ_FLAG,
    output logic ADDR_UPDATE,
    output logic DIR_READ,
    output logic CLK_RELEASE,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // system domain: firmware requests become toggles
    logic [5:0] tgl_r;
    logic [7:0] wdata_r;
    logic [7:0] oa_sys_r;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tgl_r <= '0;
        end else begin
            tgl_r <= tgl_r ^ {OVF_CLR, IRQ_CLR, CKP_SET, BUF_RD, ADDR_WR, BUF_WR};
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wdata_r <= BYTE_RST;
            oa_sys_r <= BYTE_RST;
        end else begin
            if (BUF_WR) begin
                wdata_r <= BUF_WDATA;
            end
            if (ADDR_WR) begin
                oa_sys_r <= ADDR_WDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: crossings in
    logic [EV_W-1:0] ev_s;
    logic [5:0] ev_d_r;
    logic [5:0] ev;

    isr_sync #(.W(EV_W), .RST_VAL('0)) u_sync_in (
        .CLK(LINK_CLK),
        .RST(RST),
        .D({TEN_BIT_MODE, STRETCH_ENABLE, tgl_r}),
        .Q(ev_s)
    );

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            ev_d_r <= '0;
        end else begin
            ev_d_r <= ev_s[5:0];
        end
    end

    assign ev = ev_s[5:0] ^ ev_d_r;

    logic stretch_enable;
    logic ten;
    assign stretch_enable = ev_s[LV_SEN];
    assign ten = ev_s[LV_TEN];

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling: three flops, change taken when second and third agree
    logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_d_r;

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            pin_s1_r <= PIN_IDLE;
            pin_s2_r <= PIN_IDLE;
            pin_s3_r <= PIN_IDLE;
            pin_f_r <= PIN_IDLE;
            pin_d_r <= PIN_IDLE;
        end else begin
            pin_s1_r <= {SCL_I, SDA_I};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
            pin_d_r <= pin_f_r;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, sda;
    assign sda = pin_f_r[0];
    assign scl_rise = pin_f_r[1] & ~pin_d_r[1];
    assign scl_fall = ~pin_f_r[1] & pin_d_r[1];
    assign start_det = pin_f_r[1] & pin_d_r[1] & pin_d_r[0] & ~sda;
    assign stop_det = pin_f_r[1] & pin_d_r[1] & ~pin_d_r[0] & sda;

    ////////////////////////////////////////////////////////////////////////////
    // byte framing and address decode
    isr_state_e state_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, oa_r, buf_r;
    logic buf_tgl_r, ack_r, ten_hit_r, dat_r, irq_pend_r, ua_pend_r;
    logic bf_r, ov_r, irq_r, ua_r, rw_r, ckp_r;

    logic fall8, fall9, rise9, addr_ph, hit, is_rd, take, ack_ok, nack_end;

    assign fall8 = scl_fall && cnt_r == CNT_LAST;
    assign fall9 = scl_fall && cnt_r == CNT_NINTH;
    assign rise9 = scl_rise && cnt_r == CNT_LAST;
    assign addr_ph = state_r == ST_ADDR || state_r == ST_ADDR2;
    assign is_rd = state_r == ST_ADDR && sh_r[0];
    always_comb begin
        hit = 1'b0;
        if (state_r == ST_ADDR) begin
            if (ten) begin
                hit = sh_r[7:3] == TEN_PFX && sh_r[7:1] == oa_r[7:1]
                    && (!sh_r[0] || ten_hit_r);
            end else begin
                hit = sh_r[7:1] == oa_r[7:1];
            end
        end else if (state_r == ST_ADDR2) begin
            hit = sh_r == oa_r;
        end
    end
    assign take = fall8 && ((addr_ph && hit) || state_r == ST_RX);
    assign ack_ok = take && !(bf_r || ov_r);
    assign nack_end = rise9 && state_r == ST_TX && sda;

    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_WAIT;
            cnt_r <= CNT_ZERO;
            sh_r <= BYTE_RST;
            ack_r <= 1'b0;
            ten_hit_r <= 1'b0;
            dat_r <= 1'b0;
            irq_pend_r <= 1'b0;
            ua_pend_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_WAIT;
            ack_r <= 1'b0;
            ten_hit_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            cnt_r <= CNT_ZERO;
            ack_r <= 1'b0;
        end else begin
            if (ev[EV_BUF_WR]) begin
                sh_r <= wdata_r;
            end else if (scl_rise && state_r != ST_TX && cnt_r < CNT_LAST) begin
                sh_r <= {sh_r[6:0], sda};
            end else if (scl_fall && state_r == ST_TX && cnt_r >= CNT_ONE
                         && cnt_r < CNT_LAST) begin
                sh_r <= {sh_r[6:0], 1'b0};
            end
            if (scl_rise && (state_r != ST_WAIT || cnt_r == CNT_LAST) && cnt_r < CNT_NINTH) begin
                cnt_r <= cnt_r + CNT_ONE;
            end else if (fall9) begin
                cnt_r <= CNT_ZERO;
            end
            if (fall8) begin
                ack_r <= ack_ok;
                dat_r <= state_r == ST_RX || state_r == ST_TX;
                irq_pend_r <= take || state_r == ST_TX;
                ua_pend_r <= ten && addr_ph && hit && !is_rd;
                unique case (state_r)
                    ST_ADDR: begin
                        if (!hit || !ack_ok) begin
                            state_r <= ST_WAIT;
                        end else if (is_rd) begin
                            state_r <= ST_TXA;
                        end else if (ten) begin
                            state_r <= ST_ADDR2;
                        end else begin
                            state_r <= ST_RX;
                        end
                    end
                    ST_ADDR2: begin
                        state_r <= (hit && ack_ok) ? ST_RX : ST_WAIT;
                        ten_hit_r <= hit;
                    end
                    ST_RX: begin
                        if (!ack_ok) begin
                            state_r <= ST_WAIT;
                        end
                    end
                    ST_TXA, ST_TX, ST_WAIT: begin
                    end
                    default: begin
                        state_r <= ST_WAIT;
                    end
                endcase
            end
            if (nack_end) begin
                state_r <= ST_WAIT;
            end
            if (fall9) begin
                ack_r <= 1'b0;
                if (state_r == ST_TXA) begin
                    state_r <= ST_TX;
                end
            end
        end
    end

    // received byte into the buffer, with a toggle for the system side
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            buf_r <= BYTE_RST;
            buf_tgl_r <= 1'b0;
            oa_r <= BYTE_RST;
        end else begin
            if (ack_ok) begin
                buf_r <= sh_r;
                buf_tgl_r <= ~buf_tgl_r;
            end
            if (ev[EV_ADDR_WR]) begin
                oa_r <= oa_sys_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags; hardware set wins over a same-cycle clear
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            bf_r <= 1'b0;
            ov_r <= 1'b0;
            irq_r <= 1'b0;
            ua_r <= 1'b0;
            rw_r <= 1'b0;
        end else begin
            if (ev[EV_BUF_RD] || (fall8 && state_r == ST_TX) || nack_end) begin
                bf_r <= 1'b0;
            end
            if (ack_ok || ev[EV_BUF_WR]) begin
                bf_r <= 1'b1;
            end
            if (ev[EV_OV_CLR]) begin
                ov_r <= 1'b0;
            end
            if (take && !ack_ok && state_r == ST_RX) begin
                ov_r <= 1'b1;
            end
            if (ev[EV_IRQ_CLR]) begin
                irq_r <= 1'b0;
            end
            if (fall9 && irq_pend_r) begin
                irq_r <= 1'b1;
            end
            if (ev[EV_ADDR_WR] || nack_end) begin
                ua_r <= 1'b0;
            end
            if (fall9 && ua_pend_r) begin
                ua_r <= 1'b1;
            end
            if (nack_end) begin
                rw_r <= 1'b0;
            end else if (fall8 && addr_ph && hit) begin
                rw_r <= is_rd;
            end
        end
    end

    // clock release bit: cleared at the ninth fall, firmware set wins
    always_ff @(posedge LINK_CLK or posedge RST) begin
        if (RST) begin
            ckp_r <= CKP_RST;
        end else begin
            if (fall9 && (state_r == ST_TXA
                || (state_r == ST_TX && dat_r && !bf_r)
                || (state_r == ST_RX && dat_r && ack_r && stretch_enable && bf_r))) begin
                ckp_r <= 1'b0;
            end
            if (ev[EV_CKP_SET] || nack_end) begin
                ckp_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain drivers
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = !ckp_r || (ua_r && ten);
    assign SDA_OE = ack_r || (state_r == ST_TX && !sh_r[7] && (cnt_r < CNT_LAST
        || (cnt_r == CNT_LAST && pin_f_r[1] && pin_d_r[1])));

    ////////////////////////////////////////////////////////////////////////////
    // system domain: status back from the link
    logic [ST_W-1:0] st_s;
    logic buf_tgl_d_r;

    isr_sync #(.W(ST_W), .RST_VAL(ST_RST)) u_sync_out (
        .CLK(CLK_SYS),
        .RST(RST),
        .D({buf_tgl_r, ckp_r, rw_r, ua_r, irq_r, ov_r, bf_r}),
        .Q(st_s)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            buf_tgl_d_r <= 1'b0;
            BUF_RDATA <= BYTE_RST;
        end else begin
            buf_tgl_d_r <= st_s[6];
            if (st_s[6] ^ buf_tgl_d_r) begin
                BUF_RDATA <= buf_r;
            end
        end
    end

    assign BUFFER_FULL = st_s[0];
    assign RX_OVERFLOW = st_s[1];
    assign IRQ_FLAG = st_s[2];
    assign ADDR_UPDATE = st_s[3];
    assign DIR_READ = st_s[4];
    assign CLK_RELEASE = st_s[5];

endmodule

// file: common/isr_pkg.sv
package isr_pkg;

    // address byte prefix that opens a 10-bit address
    localparam logic [4:0] TEN_PFX = 5'h1e;
    // clock counts within one byte frame
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'h8;
    localparam logic [3:0] CNT_NINTH = 4'h9;
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] PIN_IDLE = 2'h3;
    localparam logic CKP_RST = 1'b1;
    // firmware event vector into the link domain
    localparam int EV_W = 8;
    localparam int EV_BUF_WR = 0;
    localparam int EV_ADDR_WR = 1;
    localparam int EV_BUF_RD = 2;
    localparam int EV_CKP_SET = 3;
    localparam int EV_IRQ_CLR = 4;
    localparam int EV_OV_CLR = 5;
    localparam int LV_SEN = 6;
    localparam int LV_TEN = 7;
    // status vector back to the system domain
    localparam int ST_W = 7;
    localparam logic [ST_W-1:0] ST_RST = 7'h20;

    typedef enum {ST_WAIT, ST_ADDR, ST_ADDR2, ST_RX, ST_TXA, ST_TX} isr_state_e;

endpackage

// file: tb/isr_sva.sv
`timescale 1ns/1ps
module isr_sva (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic LINK_CLK,
    input wire logic CKP_SET,
    input wire logic ADDR_WR,
    input wire logic IRQ_CLR,
    input wire logic OVF_CLR,
    input wire logic BUFFER_FULL,
    input wire logic RX_OVERFLOW,
    input wire logic IRQ_FLAG,
    input wire logic ADDR_UPDATE,
    input wire logic DIR_READ,
    input wire logic CLK_RELEASE,
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE,
    input wire logic SDA_O,
    input wire logic SDA_OE
);
    localparam logic [7:0] RECENT = 8'h78;
    logic [3:0] hit;
    logic [7:0] age_r [4];
    logic fw_rel;
    assign hit = {OVF_CLR, IRQ_CLR, ADDR_WR, CKP_SET};
    assign fw_rel = (age_r[0] < RECENT) || (age_r[1] < RECENT);
    // system cycles since each CKP_SET, ADDR_WR, IRQ_CLR and OVF_CLR pulse, saturating
    always_ff @(posedge CLK_SYS or posedge RST) begin
        for (int i = 0; i < 4; i++) begin
            if (RST) begin
                age_r[i] <= 8'hff;
            end else if (hit[i]) begin
                age_r[i] <= 8'h00;
            end else if (age_r[i] != 8'hff) begin
                age_r[i] <= age_r[i] + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    AST_OD_LOW: assert property (@(posedge LINK_CLK) disable iff (RST) !SCL_O && !SDA_O)
        else $error("open-drain output not low");
    AST_SCL_GRAB: assert property (@(posedge LINK_CLK) disable iff (RST)
        $rose(SCL_OE) |-> !$past(SCL_I)) else $error("clock grabbed while high");
    AST_SDA_SETUP: assert property (@(posedge LINK_CLK) disable iff (RST)
        $changed(SDA_OE) |-> !SCL_I && !$past(SCL_I)) else $error("data moved while clock high");
    AST_SCL_FREE: assert property (@(posedge LINK_CLK) disable iff (RST)
        $fell(SCL_OE) |-> fw_rel) else $error("clock freed without firmware");
    AST_REL_UP: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(CLK_RELEASE) |-> age_r[0] < RECENT) else $error("release bit set on its own");
    AST_IRQ_CLR: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(IRQ_FLAG) |-> age_r[2] < RECENT) else $error("irq dropped on its own");
    AST_UPD_CLR: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(ADDR_UPDATE) |-> age_r[1] < RECENT) else $error("update flag dropped on its own");
    AST_OVF_FULL: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(RX_OVERFLOW) |-> BUFFER_FULL) else $error("overflow without full buffer");
    AST_OVF_CLR: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RX_OVERFLOW) |-> age_r[3] < RECENT) else $error("overflow dropped on its own");
    AST_DIR_BUF: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(DIR_READ) |-> ##[0:8] BUFFER_FULL) else $error("read address not buffered");
    COV_HOLD: cover property (@(posedge LINK_CLK) disable iff (RST) $rose(SCL_OE));
    COV_OVF: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(RX_OVERFLOW));
    COV_READ: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(DIR_READ));
endmodule

bind isr_slave_core isr_sva u_sva (.*);

// file: tb/isr_bus_master.sv
`timescale 1ns/1ps
module isr_bus_master #(
    parameter int T = 1000
) (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // data set mid-low, clock released, stretching waited out, sampled late in high
    task automatic bit_xfer(input logic b, output logic s);
        #(T / 2);
        sda_low = !b;
        #(T / 2);
        scl_low = 1'b0;
        wait (scl);
        #T;
        s = sda;
        scl_low = 1'b1;
    endtask
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], q[i]);
        end
        bit_xfer(ack_in, ack);
        #(T / 2);
        sda_low = 1'b0;
        #T;
    endtask
    task automatic start();
        sda_low = 1'b0;
        #T;
        scl_low = 1'b0;
        wait (scl);
        #T;
        sda_low = 1'b1;
        #T;
        scl_low = 1'b1;
    endtask
    task automatic stop();
        #(T / 2);
        sda_low = 1'b1;
        #(T / 2);
        scl_low = 1'b0;
        wait (scl);
        #T;
        sda_low = 1'b0;
        #T;
    endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int K_BW = 0;
    localparam int K_AW = 1;
    localparam int K_RD = 2;
    localparam int K_CK = 3;
    localparam int K_IC = 4;
    localparam int K_OC = 5;
    logic clk, rst, lclk, str_en, ten, m_scl, m_sda, a;
    logic full, ovf, irq, upd, dir, rel, scl_oe, sda_oe;
    wire logic scl, sda;
    logic [5:0] ev;
    logic [7:0] bw, aw, rdata, q;
    int mismatches, checks_done;
    assign scl = !(m_scl || scl_oe);
    assign sda = !(m_sda || sda_oe);
    isr_slave_core dut (.CLK_SYS(clk), .RST(rst), .LINK_CLK(lclk), .STRETCH_ENABLE(str_en),
        .TEN_BIT_MODE(ten), .BUF_WR(ev[0]), .BUF_WDATA(bw), .BUF_RD(ev[2]), .ADDR_WR(ev[1]),
        .ADDR_WDATA(aw), .CKP_SET(ev[3]), .IRQ_CLR(ev[4]), .OVF_CLR(ev[5]), .BUF_RDATA(rdata),
        .BUFFER_FULL(full), .RX_OVERFLOW(ovf), .IRQ_FLAG(irq), .ADDR_UPDATE(upd),
        .DIR_READ(dir), .CLK_RELEASE(rel), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
        .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe));
    isr_bus_master mst (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    initial begin
        lclk = 1'b0;
        #37;
        forever #80 lclk = !lclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one firmware pulse, then spacing for the crossing
    task automatic fw(input int k, input logic [7:0] d);
        @(posedge clk);
        #1;
        if (k == K_AW) aw = d;
        else bw = d;
        ev[k] = 1'b1;
        @(posedge clk);
        #1;
        ev = '0;
        repeat (100) @(posedge clk);
        #1;
    endtask
    task automatic xb(input logic [7:0] d, input logic ack_in, input logic exp_ack);
        mst.byte_xfer(d, ack_in, q, a);
        chk(a, exp_ack);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #900000;
        mismatches++;
        $display("watchdog expired");
        finish_test();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        str_en = 1'b1;
        ten = 1'b0;
        ev = '0;
        bw = 8'h00;
        aw = 8'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (100) @(posedge clk);
        #1;
        chk(rel, 1'b1);
        chk({full, ovf, irq, upd, dir, scl_oe, sda_oe}, 8'h00);
        chk(rdata, 8'h00);
        $display("test reset finished");
        fw(K_AW, 8'ha4);
        mst.start();
        xb(8'ha4, 1'b1, 1'b0);
        chk({dir, irq, rel, scl_oe}, 8'h06);
        chk(rdata, 8'ha4);
        fw(K_RD, 8'h00);
        fw(K_IC, 8'h00);
        chk(irq, 1'b0);
        xb(8'h3c, 1'b1, 1'b0);
        chk(rdata, 8'h3c);
        chk({rel, scl_oe}, 8'h01);
        fw(K_CK, 8'h00);
        chk({rel, scl_oe}, 8'h02);
        xb(8'h5a, 1'b1, 1'b1);
        chk({ovf, full}, 8'h03);
        chk(rdata, 8'h3c);
        fw(K_CK, 8'h00);
        mst.stop();
        fw(K_RD, 8'h00);
        fw(K_OC, 8'h00);
        fw(K_IC, 8'h00);
        chk({ovf, full, irq}, 8'h00);
        $display("test receive with stretching finished");
        str_en = 1'b0;
        mst.start();
        xb(8'ha6, 1'b1, 1'b1);
        mst.start();
        xb(8'ha4, 1'b1, 1'b0);
        fw(K_RD, 8'h00);
        xb(8'hc3, 1'b1, 1'b0);
        chk({rel, scl_oe}, 8'h02);
        chk(rdata, 8'hc3);
        mst.stop();
        fw(K_RD, 8'h00);
        fw(K_IC, 8'h00);
        $display("test receive without stretching finished");
        mst.start();
        xb(8'ha5, 1'b1, 1'b0);
        chk({dir, scl_oe}, 8'h03);
        chk(rdata, 8'ha5);
        fw(K_RD, 8'h00);
        fw(K_BW, 8'h96);
        fw(K_CK, 8'h00);
        xb(8'hff, 1'b0, 1'b0);
        chk(q, 8'h96);
        chk({rel, scl_oe}, 8'h01);
        fw(K_BW, 8'h3a);
        fw(K_CK, 8'h00);
        fork
            xb(8'hff, 1'b0, 1'b0);
            begin
                wait (!full);
                fw(K_BW, 8'h0f);
            end
        join
        chk(q, 8'h3a);
        chk({rel, scl_oe}, 8'h02);
        xb(8'hff, 1'b1, 1'b1);
        chk(q, 8'h0f);
        chk({dir, scl_oe}, 8'h00);
        mst.stop();
        fw(K_IC, 8'h00);
        $display("test transmit finished");
        ten = 1'b1;
        str_en = 1'b1;
        fw(K_AW, 8'hf2);
        mst.start();
        xb(8'hf2, 1'b1, 1'b0);
        chk({upd, rel, scl_oe}, 8'h07);
        fw(K_RD, 8'h00);
        fw(K_AW, 8'h34);
        chk({upd, scl_oe}, 8'h00);
        xb(8'h34, 1'b1, 1'b0);
        chk({upd, rel}, 8'h03);
        fw(K_AW, 8'hf2);
        fw(K_RD, 8'h00);
        chk({upd, scl_oe}, 8'h00);
        fork
            xb(8'h77, 1'b1, 1'b0);
            begin
                wait (full);
                fw(K_RD, 8'h00);
            end
        join
        chk({rel, scl_oe}, 8'h02);
        chk(rdata, 8'h77);
        mst.stop();
        $display("test ten-bit address finished");
        finish_test();
    end
endmodule
